/* rtl/ecad_pkg.sv */
/*
 * Shared constants and types for the endpoint companion attribute decoder:
 * register map, field positions, endpoint type codes, limits and carriers.
 * Assumes a single 40 MHz APB clock domain.
 */
package ecad_pkg;

    // clock and divider timing
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          DIV_STEPS       = 32;
    localparam logic [5:0]  DIV_STEPS_C     = 6'(DIV_STEPS);
    localparam int          DIV_LATENCY_MAX = DIV_STEPS + 8;

    // endpoint transfer type codes
    localparam logic [1:0]  EP_CTRL = 2'h0;
    localparam logic [1:0]  EP_ISO  = 2'h1;
    localparam logic [1:0]  EP_BULK = 2'h2;
    localparam logic [1:0]  EP_INT  = 2'h3;

    // descriptor limits
    localparam logic [4:0]  STREAM_EXP_MAX = 5'h10;
    localparam logic [16:0] STREAM_ONE     = 17'h00001;
    localparam logic [1:0]  MULT_MAX       = 2'h2;
    localparam logic [7:0]  BURST_MAX      = 8'h0F;
    localparam int          ATTR_EXT_BIT   = 7;
    localparam logic [15:0] BPI_EXT_VALUE  = 16'h0001;
    localparam logic [15:0] BPI_EXT_NEEDED = 16'hC000;

    // register byte offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_DESC    = 8'h04;
    localparam logic [7:0]  REG_MPS     = 8'h08;
    localparam logic [7:0]  REG_XBPI    = 8'h0C;
    localparam logic [7:0]  REG_STREAMS = 8'h10;
    localparam logic [7:0]  REG_MULT    = 8'h14;
    localparam logic [7:0]  REG_PKTS    = 8'h18;
    localparam logic [7:0]  REG_STATUS  = 8'h1C;
    localparam logic [7:0]  REG_MASK    = 8'h20;
    localparam logic [7:0]  REG_CAUSE   = 8'h24;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_TYPE_LSB  = 4;
    localparam int DESC_ATTR_LSB  = 0;
    localparam int DESC_BURST_LSB = 8;
    localparam int DESC_BPI_LSB   = 16;
    localparam int ST_DONE        = 0;
    localparam int ST_VIOL        = 1;
    localparam int ST_BUSY        = 2;
    localparam int EV_W           = 2;

    typedef struct packed {
        logic [1:0]  ep_type;
        logic [7:0]  attr;
        logic [7:0]  burst;
        logic [15:0] bpi;
        logic [15:0] mps;
        logic [31:0] xbpi;
    } ecad_desc_t;

    typedef struct packed {
        logic ext_div0;
        logic need_ext;
        logic ctrl_burst;
        logic burst_range;
        logic bpi_nonzero;
        logic bpi_ext;
        logic mult_burst0;
        logic mult_range;
        logic iso_rsvd;
        logic ctl_int_rsvd;
        logic stream_range;
        logic bulk_rsvd;
    } ecad_viol_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ecad_apb_req_t;

    typedef enum logic [1:0] {S_IDLE, S_DIV, S_FINISH} ecad_state_t;

endpackage : ecad_pkg

/* rtl/ecad_attr_check.sv */
/*
 * Combinational check of one companion descriptor image: reserved bits,
 * limits, stream count, packets per interval and extended-mode divisor.
 * Assumes the descriptor inputs are held stable by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module ecad_attr_check
    import ecad_pkg::*;
(
    // descriptor image
    input  wire ecad_desc_t  desc,
    // decoded results
    output ecad_viol_t       viol,
    output logic [16:0]      streams,
    output logic [7:0]       pkts,
    output logic             ext,
    output logic [31:0]      divisor
);
    logic is_ctrl;
    logic is_iso;
    logic is_bulk;
    logic is_int;
    logic [1:0] mult;
    logic [4:0] sexp;

    assign is_ctrl = desc.ep_type == EP_CTRL;
    assign is_iso  = desc.ep_type == EP_ISO;
    assign is_bulk = desc.ep_type == EP_BULK;
    assign is_int  = desc.ep_type == EP_INT;
    assign mult    = desc.attr[1:0];
    assign sexp    = desc.attr[4:0];
    assign ext     = is_iso && desc.attr[ATTR_EXT_BIT];

    assign streams = (is_bulk && sexp != 5'h00 && sexp <= STREAM_EXP_MAX)
                   ? (STREAM_ONE << sexp) : 17'h00000;
    assign viol.stream_range = is_bulk && sexp > STREAM_EXP_MAX;
    assign viol.bulk_rsvd    = is_bulk && desc.attr[7:5] != 3'h0;
    assign viol.ctl_int_rsvd = (is_ctrl || is_int) && desc.attr != 8'h00;
    assign viol.iso_rsvd     = is_iso && desc.attr[6:2] != 5'h00;
    assign viol.mult_range   = is_iso && !ext && mult > MULT_MAX;
    assign viol.mult_burst0  = is_iso && !ext && desc.burst == 8'h00 && mult != 2'h0;
    assign viol.bpi_ext      = ext && desc.bpi != BPI_EXT_VALUE;
    assign viol.bpi_nonzero  = (is_ctrl || is_bulk) && desc.bpi != 16'h0000;
    assign viol.burst_range  = desc.burst > BURST_MAX;
    assign viol.ctrl_burst   = is_ctrl && desc.burst != 8'h00;
    // large budget needs the extended companion
    assign viol.need_ext     = is_iso && !ext && desc.bpi > BPI_EXT_NEEDED;
    // a zero divisor makes the extended quotient meaningless
    assign viol.ext_div0     = ext && divisor == 32'h00000000;

    assign pkts    = 8'(({4'h0, desc.burst[3:0]} + 8'h01) * ({6'h00, mult} + 8'h01));
    assign divisor = {8'h00, 24'(desc.burst * desc.mps)};

endmodule : ecad_attr_check
`default_nettype wire

/* rtl/ecad_ceil_div.sv */
/*
 * Sequential 32-bit divider giving the quotient rounded up.
 * Assumes divisor is nonzero and start is ignored while busy.
 */
`timescale 1ns/1ps
`default_nettype none
module ecad_ceil_div
    import ecad_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    // answer
    output logic             done,
    output logic [31:0]      quotient
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  cnt;
        logic [32:0] rem;
        logic [31:0] quo;
        logic [31:0] dvs;
        logic [31:0] res;
    } ecad_div_st_t;

    ecad_div_st_t r_reg;
    ecad_div_st_t r_next;

    always_comb begin
        logic [32:0] rem_sh;
        logic [31:0] quo_sh;
        rem_sh = {r_reg.rem[31:0], r_reg.quo[31]};
        quo_sh = {r_reg.quo[30:0], 1'b0};
        r_next = r_reg;
        r_next.done = 1'b0;
        if (rem_sh >= {1'b0, r_reg.dvs}) begin
            rem_sh = rem_sh - {1'b0, r_reg.dvs};
            quo_sh[0] = 1'b1;
        end
        if (start && !r_reg.busy) begin
            r_next.busy = 1'b1;
            r_next.cnt  = DIV_STEPS_C;
            r_next.rem  = 33'h000000000;
            r_next.quo  = dividend;
            r_next.dvs  = divisor;
        end else if (r_reg.busy) begin
            r_next.rem = rem_sh;
            r_next.quo = quo_sh;
            r_next.cnt = r_reg.cnt - 6'h01;
            if (r_reg.cnt == 6'h01) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
                r_next.res  = quo_sh + {31'h00000000, |rem_sh};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done     = r_reg.done;
    assign quotient = r_reg.res;

endmodule : ecad_ceil_div
`default_nettype wire

/* rtl/ecad_top.sv */
/*
 * Endpoint companion attribute decoder with APB register access,
 * sticky event status, mask and a level interrupt.
 * Assumes a single-clock APB master on pclk; pready is always high.
 */
// The address map and the APB interface to the registers are this design's own decisions.
// Summary of operation
// - bulk attribute bits 4:0 give stream exponent 0..16, streams equal 2^n for n 1..16 and zero for n 0.
// - bulk attribute bits 7:5 must be zero, else violation.
// - control and interrupt attribute byte must be entirely zero.
// - iso bits 1:0 are Mult; packets equal (burst+1) times (Mult+1).
// - iso Mult never above 2 and zero when burst is zero.
// - iso attribute bits 6:2 must be zero.
// - iso bit 7 announces extended companion; Mult field then ignored.
// - extended Mult is bytes over burst over packet size, rounded up.
// - two-byte interval byte count sits at offset 4, periodic only.
// - with extended companion the interval byte count must be one.
// - control and bulk interval byte count must be zero.
// - burst lies in 0..15 and is zero for control endpoints.
// - iso endpoints above 48K bytes per interval need extended companion.
`timescale 1ns/1ps
`default_nettype none
module ecad_top
    import ecad_pkg::*;
(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire ecad_apb_req_t apb_req,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // events
    output logic               irq,
    output logic               viol_pulse
);
    typedef struct packed {
        ecad_state_t       state;
        ecad_desc_t        desc;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   mask;
        logic [16:0]       streams;
        logic [31:0]       mult;
        logic [31:0]       pkts;
        ecad_viol_t        cause;
        logic              viol_pulse;
        logic              div_start;
        logic [31:0]       rdata;
    } ecad_top_st_t;

    ecad_top_st_t r_reg;
    ecad_top_st_t r_next;

    ecad_viol_t   chk_viol;
    logic [16:0]  chk_streams;
    logic [7:0]   chk_pkts;
    logic         chk_ext;
    logic [31:0]  chk_div;
    logic         div_done;
    logic [31:0]  div_q;
    logic         need_div;
    logic         start_ext;
    logic         wr_acc;
    logic         rd_setup;
    logic         mapped;

    ecad_attr_check u_check (
        .desc    (r_reg.desc),
        .viol    (chk_viol),
        .streams (chk_streams),
        .pkts    (chk_pkts),
        .ext     (chk_ext),
        .divisor (chk_div)
    );

    ecad_ceil_div u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (r_reg.div_start),
        .dividend (r_reg.desc.xbpi),
        .divisor  (chk_div),
        .done     (div_done),
        .quotient (div_q)
    );

    // type arrives with the start write, so the stored type is still stale
    assign start_ext = apb_req.pwdata[CTRL_TYPE_LSB +: 2] == EP_ISO
                       && r_reg.desc.attr[ATTR_EXT_BIT];
    assign need_div  = start_ext && chk_div != 32'h00000000;
    assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    always_comb begin
        case (apb_req.paddr)
            REG_CTRL, REG_DESC, REG_MPS, REG_XBPI, REG_STREAMS,
            REG_MULT, REG_PKTS, REG_STATUS, REG_MASK, REG_CAUSE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        logic            start;
        logic [EV_W-1:0] clr;
        logic [EV_W-1:0] set;
        start = 1'b0;
        clr   = '0;
        set   = '0;
        r_next = r_reg;
        r_next.viol_pulse = 1'b0;
        r_next.div_start  = 1'b0;
        // descriptor image is frozen while a decode runs
        if (wr_acc) begin
            case (apb_req.paddr)
                REG_CTRL: if (r_reg.state == S_IDLE) begin
                    r_next.desc.ep_type = apb_req.pwdata[CTRL_TYPE_LSB +: 2];
                    start = apb_req.pwdata[CTRL_START_BIT];
                end
                REG_DESC: if (r_reg.state == S_IDLE) begin
                    r_next.desc.attr  = apb_req.pwdata[DESC_ATTR_LSB +: 8];
                    r_next.desc.burst = apb_req.pwdata[DESC_BURST_LSB +: 8];
                    r_next.desc.bpi   = apb_req.pwdata[DESC_BPI_LSB +: 16];
                end
                REG_MPS: if (r_reg.state == S_IDLE) begin
                    r_next.desc.mps = apb_req.pwdata[15:0];
                end
                REG_XBPI: if (r_reg.state == S_IDLE) begin
                    r_next.desc.xbpi = apb_req.pwdata;
                end
                REG_STATUS: clr = apb_req.pwdata[EV_W-1:0];
                REG_MASK: r_next.mask = apb_req.pwdata[EV_W-1:0];
                default: ;
            endcase
        end
        case (r_reg.state)
            S_IDLE: if (start) begin
                // mult field ignored in extended mode
                r_next.mult = start_ext ? 32'h00000000 : {30'h00000000, r_reg.desc.attr[1:0]};
                if (need_div) begin
                    r_next.state     = S_DIV;
                    r_next.div_start = 1'b1;
                end else begin
                    r_next.state = S_FINISH;
                end
            end
            S_DIV: if (div_done) begin
                r_next.mult  = div_q;
                r_next.state = S_FINISH;
            end
            S_FINISH: begin
                r_next.streams = chk_streams;
                r_next.pkts = chk_ext
                    ? 32'(({24'h000000, r_reg.desc.burst} + 32'h00000001) * r_reg.mult)
                    : {24'h000000, chk_pkts};
                r_next.cause = chk_viol;
                r_next.viol_pulse = |chk_viol;
                set[ST_DONE] = 1'b1;
                set[ST_VIOL] = |chk_viol;
                r_next.state = S_IDLE;
            end
            default: r_next.state = S_IDLE;
        endcase
        // set wins over a same-cycle clear
        r_next.status = (r_reg.status & ~clr) | set;
        if (rd_setup) begin
            case (apb_req.paddr)
                REG_CTRL:    r_next.rdata = {26'h0000000, r_reg.desc.ep_type, 4'h0};
                REG_DESC:    r_next.rdata = {r_reg.desc.bpi, r_reg.desc.burst, r_reg.desc.attr};
                REG_MPS:     r_next.rdata = {16'h0000, r_reg.desc.mps};
                REG_XBPI:    r_next.rdata = r_reg.desc.xbpi;
                REG_STREAMS: r_next.rdata = {15'h0000, r_reg.streams};
                REG_MULT:    r_next.rdata = r_reg.mult;
                REG_PKTS:    r_next.rdata = r_reg.pkts;
                REG_STATUS:  r_next.rdata = {29'h00000000, r_reg.state != S_IDLE, r_reg.status};
                REG_MASK:    r_next.rdata = {30'h00000000, r_reg.mask};
                REG_CAUSE:   r_next.rdata = {20'h00000, r_reg.cause};
                default:     r_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata     = r_reg.rdata;
    assign pready     = 1'b1;
    assign pslverr    = apb_req.psel && apb_req.penable && !mapped;
    assign irq        = |(r_reg.status & r_reg.mask);
    assign viol_pulse = r_reg.viol_pulse;

    // checking
    logic [63:0] chk_hi;
    logic [63:0] chk_lo;
    logic        fin;
    logic [1:0]  ty;
    assign chk_hi = 64'(r_reg.mult) * 64'(chk_div);
    assign chk_lo = 64'(r_reg.mult - 32'h00000001) * 64'(chk_div);
    assign fin    = r_reg.state == S_FINISH;
    assign ty     = r_reg.desc.ep_type;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fin_to_done;
        fin ##1 (r_reg.status[ST_DONE] && r_reg.state == S_IDLE);
    endsequence

    property p_start_plain;
        (r_reg.state == S_IDLE && wr_acc && apb_req.paddr == REG_CTRL
         && apb_req.pwdata[CTRL_START_BIT] && !need_div) |=> s_fin_to_done;
    endproperty
    a_start_plain: assert property (p_start_plain) else $error("decode did not finish");

    property p_div_bound;
        (r_reg.state == S_DIV) |-> ##[1:40] fin;
    endproperty
    a_div_bound: assert property (p_div_bound) else $error("divide too slow");

    property p_ext_mult;
        (fin && chk_ext && !chk_viol.ext_div0)
        |-> (chk_hi >= 64'(r_reg.desc.xbpi)) && (r_reg.mult == 32'h00000000
             || chk_lo < 64'(r_reg.desc.xbpi));
    endproperty
    a_ext_mult: assert property (p_ext_mult) else $error("extended mult not ceiling");

    property p_ext_ignore;
        (fin && chk_ext) |=> !r_reg.cause.mult_range && !r_reg.cause.mult_burst0;
    endproperty
    a_ext_ignore: assert property (p_ext_ignore) else $error("mult checked in ext");

    property p_streams;
        (fin && ty == EP_BULK && r_reg.desc.attr[4:0] != 5'h00
         && r_reg.desc.attr[4:0] <= STREAM_EXP_MAX)
        |=> r_reg.streams == (STREAM_ONE << $past(r_reg.desc.attr[4:0]));
    endproperty
    a_streams: assert property (p_streams) else $error("stream count wrong");

    property p_bulk_rsvd;
        (fin && ty == EP_BULK && r_reg.desc.attr[7:5] != 3'h0)
        |=> r_reg.cause.bulk_rsvd && r_reg.viol_pulse && r_reg.status[ST_VIOL];
    endproperty
    a_bulk_rsvd: assert property (p_bulk_rsvd) else $error("bulk reserved missed");

    property p_ci_rsvd;
        (fin && (ty == EP_CTRL || ty == EP_INT) && r_reg.desc.attr != 8'h00)
        |=> r_reg.cause.ctl_int_rsvd;
    endproperty
    a_ci_rsvd: assert property (p_ci_rsvd) else $error("ctrl/int reserved missed");

    property p_pkts;
        (fin && ty == EP_ISO && !chk_ext)
        |=> r_reg.pkts == 32'(($past(r_reg.desc.burst[3:0]) + 32'h00000001)
                              * ($past(r_reg.desc.attr[1:0]) + 32'h00000001));
    endproperty
    a_pkts: assert property (p_pkts) else $error("packet count wrong");

    property p_mult_lim;
        (fin && ty == EP_ISO && !chk_ext && r_reg.desc.attr[1:0] > MULT_MAX)
        |=> r_reg.cause.mult_range;
    endproperty
    a_mult_lim: assert property (p_mult_lim) else $error("mult limit missed");

    property p_iso_rsvd;
        (fin && ty == EP_ISO && r_reg.desc.attr[6:2] != 5'h00) |=> r_reg.cause.iso_rsvd;
    endproperty
    a_iso_rsvd: assert property (p_iso_rsvd) else $error("iso reserved missed");

    property p_bpi_ext;
        (fin && chk_ext && r_reg.desc.bpi != BPI_EXT_VALUE) |=> r_reg.cause.bpi_ext;
    endproperty
    a_bpi_ext: assert property (p_bpi_ext) else $error("ext interval count missed");

    property p_bpi_zero;
        (fin && (ty == EP_CTRL || ty == EP_BULK) && r_reg.desc.bpi != 16'h0000)
        |=> r_reg.cause.bpi_nonzero;
    endproperty
    a_bpi_zero: assert property (p_bpi_zero) else $error("nonzero interval missed");

    property p_burst;
        (fin && (r_reg.desc.burst > BURST_MAX || (ty == EP_CTRL && r_reg.desc.burst != 8'h00)))
        |=> r_reg.viol_pulse;
    endproperty
    a_burst: assert property (p_burst) else $error("burst fault missed");

    property p_need_ext;
        (fin && ty == EP_ISO && !chk_ext && r_reg.desc.bpi > BPI_EXT_NEEDED)
        |=> r_reg.cause.need_ext;
    endproperty
    a_need_ext: assert property (p_need_ext) else $error("large budget missed");

    property p_pulse;
        viol_pulse |-> $past(fin) && r_reg.cause != '0 ##1 !viol_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("violation pulse malformed");

endmodule : ecad_top
`default_nettype wire

/* testbench/ecad_host_model.sv */
/*
 * Host-side APB master for the companion attribute decoder.
 * Assumes pclk from the bench; waits on pready as long as the slave asks.
 */
`timescale 1ns/1ps
`default_nettype none
module ecad_host_model
    import ecad_pkg::*;
(
    // bus
    input  wire logic        pclk,
    output var ecad_apb_req_t apb_req,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial apb_req = '0;

    // request held until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apb_req <= '0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask : wr

    // decoded figures read back for scheduling
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
        xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
endmodule : ecad_host_model
`default_nettype wire

/* testbench/ecad_top_tb.sv */
/*
 * Self-checking bench for the companion attribute decoder.
 * Assumes the host model drives APB; mps fixed at 1024 bytes.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %s", $time, m); end end
module ecad_top_tb;
    import ecad_pkg::*;
    logic          pclk;
    logic          presetn;
    ecad_apb_req_t apb_req;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    logic          viol_pulse;
    logic [31:0]   cause;
    logic [31:0]   streams;
    logic [31:0]   mult;
    logic [31:0]   pkts;
    logic [31:0]   q;
    logic          e;
    int            n_errors;
    int            total_checks;
    int            n_pulse;
    int            cycles;

    ecad_top uut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .viol_pulse(viol_pulse));
    ecad_host_model host (.pclk(pclk), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (viol_pulse === 1'b1) n_pulse++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic dec(input logic [1:0] t, input logic [31:0] d, input logic [31:0] x,
                       input logic [11:0] exp_c);
        int          k;
        int          p0;
        logic [31:0] s;
        host.wr(REG_STATUS, 32'h3);
        host.wr(REG_DESC, d);
        host.wr(REG_MPS, 32'h400);
        host.wr(REG_XBPI, x);
        p0 = n_pulse;
        host.wr(REG_CTRL, {26'h0, t, 4'h1});
        k = 0;
        s = '0;
        while (s[ST_DONE] !== 1'b1 && k < 60) begin
            host.rd(REG_STATUS, s, e);
            k++;
        end
        `CHK(s[ST_DONE], 1'b1, "decode done")
        host.rd(REG_CAUSE, cause, e);
        `CHK(cause[11:0], exp_c, "fault cause")
        `CHK(s[ST_VIOL], |exp_c, "violation status")
        `CHK(n_pulse - p0, (exp_c != 0) ? 1 : 0, "violation pulse")
        host.rd(REG_STREAMS, streams, e);
        host.rd(REG_MULT, mult, e);
        host.rd(REG_PKTS, pkts, e);
    endtask : dec

    task automatic t_reset();
        host.rd(REG_STATUS, q, e);
        `CHK(q, 32'h0, "status after reset")
        host.rd(REG_MASK, q, e);
        `CHK(q, 32'h0, "mask after reset")
        `CHK(pready, 1'b1, "pready high")
        host.rd(8'h28, q, e);
        `CHK({q, e}, 33'h1, "unmapped read")
    endtask : t_reset

    task automatic t_bulk();
        dec(EP_BULK, 32'h0, 32'h0, 12'h0);
        `CHK(streams[16:0], 17'h0, "no streams")
        dec(EP_BULK, 32'h1, 32'h0, 12'h0);
        `CHK(streams[16:0], 17'h2, "two streams")
        dec(EP_BULK, 32'h10, 32'h0, 12'h0);
        `CHK(streams[16:0], 17'h10000, "max streams")
        dec(EP_BULK, 32'h11, 32'h0, 12'h2);
        dec(EP_BULK, 32'h20, 32'h0, 12'h1);
        dec(EP_BULK, 32'h0010_0000, 32'h0, 12'h80);
        dec(EP_BULK, 32'h1000, 32'h0, 12'h100);
    endtask : t_bulk

    task automatic t_ctl_int();
        dec(EP_CTRL, 32'h1, 32'h0, 12'h4);
        dec(EP_INT, 32'h80, 32'h0, 12'h4);
        dec(EP_CTRL, 32'h100, 32'h0, 12'h200);
        dec(EP_CTRL, 32'h0001_0000, 32'h0, 12'h80);
        dec(EP_INT, 32'h0400_0300, 32'h0, 12'h0);
    endtask : t_ctl_int

    task automatic t_iso();
        dec(EP_ISO, 32'h0400_0302, 32'h0, 12'h0);
        `CHK({mult, pkts}, {32'h2, 32'hC}, "plain packets")
        dec(EP_ISO, 32'h0400_0303, 32'h0, 12'h10);
        dec(EP_ISO, 32'h0400_0001, 32'h0, 12'h20);
        dec(EP_ISO, 32'h0400_0004, 32'h0, 12'h8);
        dec(EP_ISO, 32'hC001_0000, 32'h0, 12'h400);
        dec(EP_ISO, 32'hC000_0000, 32'h0, 12'h0);
    endtask : t_iso

    task automatic t_ext();
        dec(EP_ISO, 32'h0001_0283, 32'd5000, 12'h0);
        `CHK({mult, pkts}, {32'h3, 32'h9}, "extended rounded up")
        dec(EP_BULK, 32'h0, 32'h0, 12'h0);
        dec(EP_ISO, 32'h0001_0280, 32'd4096, 12'h0);
        `CHK({mult, pkts}, {32'h2, 32'h6}, "extended exact")
        dec(EP_ISO, 32'h0002_0280, 32'd4096, 12'h40);
        dec(EP_ISO, 32'h0001_0080, 32'd4096, 12'h800);
        `CHK({mult, pkts}, {32'h0, 32'h0}, "extended zero divisor")
    endtask : t_ext

    task automatic t_irq();
        host.wr(REG_MASK, 32'h2);
        dec(EP_BULK, 32'h0, 32'h0, 12'h0);
        @(negedge pclk);
        `CHK(irq, 1'b0, "done masked")
        host.wr(REG_MASK, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b1, "done unmasked")
        host.wr(REG_STATUS, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b0, "done cleared")
        host.wr(REG_MASK, 32'h2);
        dec(EP_CTRL, 32'h1, 32'h0, 12'h4);
        @(negedge pclk);
        `CHK(irq, 1'b1, "violation irq")
    endtask : t_irq

    initial begin
        presetn = 1'b0;
        n_errors = 0;
        total_checks = 0;
        n_pulse = 0;
        cycles = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_bulk();
        t_ctl_int();
        t_iso();
        t_ext();
        t_irq();
        end_sim();
    end
endmodule : ecad_top_tb
`default_nettype wire
